// >>> ddcrm_pkg.sv
// Shared constants and types for the downconverter control register map.
// Assumes a single 40 MHz clock domain and an AXI4-Lite master on the register side.
package ddcrm_pkg;

	// Bus geometry: register index times four is the byte address
	localparam int ADDR_W = 10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register indices
	localparam logic [7:0] IDX_DEC = 8'h00;
	localparam logic [7:0] IDX_DEC_HI = 8'h01;
	localparam logic [7:0] IDX_SCALE = 8'h02;
	localparam logic [7:0] IDX_GAIN_A = 8'h03;
	localparam logic [7:0] IDX_GAIN_B = 8'h04;
	localparam logic [7:0] IDX_RATE = 8'h05;
	localparam logic [7:0] IDX_SERIAL = 8'h06;
	localparam logic [7:0] IDX_CHANNEL_A_TUNING_FREQUENCY = 8'h07;
	localparam logic [7:0] IDX_PHASE_A = 8'h0B;
	localparam logic [7:0] IDX_CHANNEL_B_TUNING_FREQUENCY = 8'h0D;
	localparam logic [7:0] IDX_PHASE_B = 8'h11;
	localparam logic [7:0] IDX_SOURCE = 8'h13;
	localparam logic [7:0] IDX_LOOP_CTRL = 8'h14;
	localparam logic [7:0] IDX_LOOP_CNT = 8'h15;
	localparam logic [7:0] IDX_LOOP_CNT_HI = 8'h16;
	localparam logic [7:0] IDX_INIT_A = 8'h17;
	localparam logic [7:0] IDX_INIT_B = 8'h18;
	localparam logic [7:0] IDX_RB_A = 8'h19;
	localparam logic [7:0] IDX_RB_B = 8'h1A;
	localparam logic [7:0] IDX_TEST = 8'h1B;
	localparam logic [7:0] IDX_TEST_HI = 8'h1C;
	localparam logic [7:0] IDX_RSVD_A = 8'h1D;
	localparam logic [7:0] IDX_RSVD_B = 8'h1E;
	localparam logic [7:0] IDX_DEBUG = 8'h1F;
	localparam logic [7:0] IDX_LUT = 8'h80;
	localparam logic [7:0] IDX_LUT_LAST = 8'h9F;
	localparam logic [7:0] IDX_F1 = 8'hA0;
	localparam logic [7:0] IDX_F1_LAST = 8'hB5;
	localparam logic [7:0] IDX_F2 = 8'hB6;
	localparam logic [7:0] IDX_F2_LAST = 8'hF5;
	localparam logic [7:0] IDX_FIRST_FILTER_BANK_CONTROL = 8'hF6;
	localparam logic [7:0] IDX_SECOND_FILTER_BANK_CONTROL = 8'hF7;
	localparam logic [7:0] IDX_SER_CTRL = 8'hF8;
	localparam logic [7:0] IDX_DET_CTRL = 8'hF9;

	// Slots of the upper control group (index minus IDX_FIRST_FILTER_BANK_CONTROL)
	localparam logic [1:0] C2_F1 = 2'h0;
	localparam logic [1:0] C2_F2 = 2'h1;
	localparam logic [1:0] C2_SER = 2'h2;
	localparam logic [1:0] C2_DET = 2'h3;

	// Writable bit masks of partially used registers
	localparam logic [7:0] MASK_DEC_HI = 8'h17;
	localparam logic [7:0] MASK_SCALE = 8'h3F;
	localparam logic [7:0] MASK_GAIN = 8'h07;
	localparam logic [7:0] MASK_SOURCE = 8'h0F;
	localparam logic [7:0] MASK_LOOP_CTRL = 8'h39;
	localparam logic [7:0] MASK_TEST_HI = 8'h3F;
	localparam logic [7:0] MASK_BANK_CTRL = 8'h07;
	localparam logic [7:0] MASK_SER_CTRL = 8'h03;
	localparam logic [7:0] MASK_DET_CTRL = 8'h7F;

	// Field positions
	localparam int DECIMATION_HIGH_AND_SECOND_RATIO_BIT = 4;
	localparam int PAGE_BIT = 2;
	localparam int FRAME_MODE_BIT = 0;
	localparam int DAISY_BIT = 1;
	localparam int COMB_LSB = 0;
	localparam int DELAY_LSB = 2;

	// Reset values
	localparam logic [7:0] RESET_DEBUG = 8'h80;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// Memory depths
	localparam int LUT_DEPTH = 32;
	localparam int F1_BYTES = 22;
	localparam int F1_TAPS = 11;
	localparam int F2_BYTES = 64;
	localparam int DELAY_DEPTH = 31;

	typedef enum logic [2:0] {
		RG_CTRL = 3'h0,
		RG_LUT = 3'h1,
		RG_F1 = 3'h3,
		RG_F2 = 3'h2,
		RG_CTRL2 = 3'h6,
		RG_NONE = 3'h7
	} ddcrm_region_t;

	typedef struct packed {
		logic [2:0] gain_code;
		logic [7:0] loop_readback;
		logic [3:0] f1_tap;
		logic [4:0] f2_tap;
		logic [4:0] lut_addr;
	} ddcrm_chan_in_t;

	typedef struct packed {
		logic [15:0] f1_coef;
		logic [15:0] f2_coef;
		logic [7:0] lut_entry;
		logic [2:0] amp_gain_code;
		logic amp_latch_strobe;
		logic [2:0] comp_gain_code;
	} ddcrm_chan_out_t;

	typedef struct packed {
		logic [10:0] dec_ratio;
		logic decimation_high_and_second_ratio;
		logic [5:0] scale_shift;
		logic [2:0] gain_a;
		logic [2:0] gain_b;
		logic [7:0] out_rate;
		logic [7:0] serial_ctrl;
		logic [31:0] channel_a_tuning_frequency;
		logic [15:0] phase_a;
		logic [31:0] channel_b_tuning_frequency;
		logic [15:0] phase_b;
		logic [3:0] input_sel;
		logic [7:0] loop_ctrl;
		logic [7:0] loop_init_a;
		logic [7:0] loop_init_b;
		logic [13:0] test_ctrl;
		logic [7:0] probe_ctrl;
		logic [1:0] first_filter_bank;
		logic [1:0] second_filter_bank;
		logic frame_sync_mode;
		logic daisy_chain_master_enable;
		logic [1:0] detector_comb_order;
		logic [4:0] gain_step_align_delay;
	} ddcrm_cfg_t;

	typedef struct packed {
		logic aw_full;
		logic [7:0] aw_idx;
		logic w_full;
		logic [7:0] w_data;
		logic w_lane;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic [31:0][7:0] ctrl;
		logic [3:0][7:0] ctrl2;
		logic [31:0][7:0] lut;
		logic [21:0][7:0] f1a;
		logic [21:0][7:0] f1b;
		logic [63:0][7:0] f2a;
		logic [63:0][7:0] f2b;
		logic [1:0][2:0] code_prev;
		logic [1:0] strobe;
		logic [1:0][30:0][2:0] hist;
		logic [1:0][15:0] f1c;
		logic [1:0][15:0] f2c;
		logic [1:0][7:0] lut_out;
	} ddcrm_state_t;

endpackage : ddcrm_pkg

// >>> ddcrm_top.sv
// Control register map of a two-channel downconverter with gain loop.
// Assumes an AXI4-Lite master on CLK and datapath logic on the same clock.
//
// Function
// - Each channel's first filter reads coefficient bank A when its first-filter select is 0, else bank B.
// - Each channel's second filter reads coefficient bank A when its second-filter select is 0, else B.
// - Host access to the first-filter coefficient range reaches bank A when page bit 2 is 0, else B.
// - Host access to the second-filter coefficient range reaches bank A when its page bit is 0, else B.
// - Frame-sync mode 0 marks each word or I/Q pair, mode 1 marks each output sample period.
// - The daisy-chain enable bit selects normal serial mode at 0 and daisy-chain master at 1.
// - A two-bit comb-order field selects the plain, one-tap or four-tap power detector comb.
// - A five-bit field delays the digital gain compensation step by that many clock periods.
// - Reset loads every default, zero for the upper control fields; sync-in changes nothing.
// - The gain-loop table sits at indices 128 to 159, first entry at the lowest index.
// - Coefficients load upward from index 160 or 182, low byte at the lower index.
// - The gain-loop table holds 32 signed bytes shared by both channels.
// - The first filter holds 11 signed 16-bit coefficients, two bytes each.
// - A channel's amplifier latch strobe toggles only when its gain code has just changed.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ddcrm_top
	import ddcrm_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// AXI4-Lite write address and data
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic [2:0] AWPROT,
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	// AXI4-Lite write response
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	// AXI4-Lite read
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic [2:0] ARPROT,
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	// Datapath side, index 0 is channel A
	input ddcrm_chan_in_t [1:0] CHAN_IN,
	output ddcrm_chan_out_t [1:0] CHAN_OUT,
	output ddcrm_cfg_t CFG
);

	ddcrm_state_t s;
	ddcrm_state_t next_s;

	function automatic ddcrm_region_t region_of(input logic [7:0] idx);
		if (idx <= IDX_DEBUG) begin
			region_of = RG_CTRL;
		end else if (idx >= IDX_LUT && idx <= IDX_LUT_LAST) begin
			region_of = RG_LUT;
		end else if (idx >= IDX_F1 && idx <= IDX_F1_LAST) begin
			region_of = RG_F1;
		end else if (idx >= IDX_F2 && idx <= IDX_F2_LAST) begin
			region_of = RG_F2;
		end else if (idx >= IDX_FIRST_FILTER_BANK_CONTROL && idx <= IDX_DET_CTRL) begin
			region_of = RG_CTRL2;
		end else begin
			region_of = RG_NONE;
		end
	endfunction : region_of

	// Writable bits; zero mask keeps reserved and read-only bytes at zero
	function automatic logic [7:0] wmask(input logic [7:0] idx);
		case (idx)
			IDX_DEC_HI: wmask = MASK_DEC_HI;
			IDX_SCALE: wmask = MASK_SCALE;
			IDX_GAIN_A, IDX_GAIN_B: wmask = MASK_GAIN;
			IDX_SOURCE: wmask = MASK_SOURCE;
			IDX_LOOP_CTRL: wmask = MASK_LOOP_CTRL;
			IDX_LOOP_CNT, IDX_LOOP_CNT_HI, IDX_RB_A, IDX_RB_B,
			IDX_RSVD_A, IDX_RSVD_B: wmask = 8'h00;
			IDX_TEST_HI: wmask = MASK_TEST_HI;
			IDX_FIRST_FILTER_BANK_CONTROL, IDX_SECOND_FILTER_BANK_CONTROL: wmask = MASK_BANK_CTRL;
			IDX_SER_CTRL: wmask = MASK_SER_CTRL;
			IDX_DET_CTRL: wmask = MASK_DET_CTRL;
			default: wmask = 8'hFF;
		endcase
	endfunction : wmask

	function automatic logic [7:0] rd_byte(input ddcrm_state_t st, input logic [7:0] idx,
		input logic [7:0] rb_a, input logic [7:0] rb_b);
		logic [7:0] off;
		case (region_of(idx))
			RG_CTRL: off = idx;
			RG_LUT: off = 8'(idx - IDX_LUT);
			RG_F1: off = 8'(idx - IDX_F1);
			RG_F2: off = 8'(idx - IDX_F2);
			RG_CTRL2: off = 8'(idx - IDX_FIRST_FILTER_BANK_CONTROL);
			default: off = 8'h00;
		endcase
		case (region_of(idx))
			RG_CTRL: begin
				if (idx == IDX_RB_A) begin
					rd_byte = rb_a;
				end else if (idx == IDX_RB_B) begin
					rd_byte = rb_b;
				end else begin
					rd_byte = st.ctrl[off[4:0]];
				end
			end
			RG_LUT: rd_byte = st.lut[off[4:0]];
			RG_F1: rd_byte = st.ctrl2[C2_F1][PAGE_BIT] ? st.f1b[off[4:0]] : st.f1a[off[4:0]];
			RG_F2: rd_byte = st.ctrl2[C2_F2][PAGE_BIT] ? st.f2b[off[5:0]] : st.f2a[off[5:0]];
			RG_CTRL2: rd_byte = st.ctrl2[off[1:0]];
			default: rd_byte = 8'h00;
		endcase
	endfunction : rd_byte

	// Coefficient n is {byte 2n+1, byte 2n}; taps past the last read zero
	function automatic logic [15:0] f1_coef(input logic [21:0][7:0] mem, input logic [3:0] tap);
		if (tap < 4'(F1_TAPS)) begin
			f1_coef = {mem[{tap, 1'b1}], mem[{tap, 1'b0}]};
		end else begin
			f1_coef = 16'h0000;
		end
	endfunction : f1_coef

	function automatic logic [15:0] f2_coef(input logic [63:0][7:0] mem, input logic [4:0] tap);
		f2_coef = {mem[{tap, 1'b1}], mem[{tap, 1'b0}]};
	endfunction : f2_coef

	always_comb begin
		logic [7:0] off;
		logic [7:0] wbyte;
		ddcrm_region_t wreg;
		off = 8'h00;
		wbyte = 8'h00;
		wreg = region_of(s.aw_idx);
		next_s = s;

		// Write address and data are taken independently, in either order
		if (AWVALID && AWREADY) begin
			next_s.aw_full = 1'b1;
			next_s.aw_idx = AWADDR[9:2];
		end
		if (WVALID && WREADY) begin
			next_s.w_full = 1'b1;
			next_s.w_data = WDATA[7:0];
			next_s.w_lane = WSTRB[0];
		end
		if (s.bvalid && BREADY) begin
			next_s.bvalid = 1'b0;
		end

		if (s.aw_full && s.w_full && !s.bvalid) begin
			next_s.aw_full = 1'b0;
			next_s.w_full = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = (wreg == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
			wbyte = (s.w_data & wmask(s.aw_idx));
			// Only byte lane 0 carries data; other lanes are ignored
			if (s.w_lane) begin
				case (wreg)
					RG_CTRL: begin
						off = s.aw_idx;
						next_s.ctrl[off[4:0]] = wbyte;
					end
					RG_LUT: begin
						off = 8'(s.aw_idx - IDX_LUT);
						next_s.lut[off[4:0]] = wbyte;
					end
					RG_F1: begin
						off = 8'(s.aw_idx - IDX_F1);
						if (s.ctrl2[C2_F1][PAGE_BIT]) begin
							next_s.f1b[off[4:0]] = wbyte;
						end else begin
							next_s.f1a[off[4:0]] = wbyte;
						end
					end
					RG_F2: begin
						off = 8'(s.aw_idx - IDX_F2);
						if (s.ctrl2[C2_F2][PAGE_BIT]) begin
							next_s.f2b[off[5:0]] = wbyte;
						end else begin
							next_s.f2a[off[5:0]] = wbyte;
						end
					end
					RG_CTRL2: begin
						off = 8'(s.aw_idx - IDX_FIRST_FILTER_BANK_CONTROL);
						next_s.ctrl2[off[1:0]] = wbyte;
					end
					default: begin
						off = 8'h00;
					end
				endcase
			end
		end

		// One read outstanding; unmapped indices answer zero with an error
		if (s.rvalid && RREADY) begin
			next_s.rvalid = 1'b0;
		end
		if (ARVALID && ARREADY) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = rd_byte(s, ARADDR[9:2], CHAN_IN[0].loop_readback,
				CHAN_IN[1].loop_readback);
			next_s.rresp = (region_of(ARADDR[9:2]) == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
		end

		// Per-channel datapath service
		for (int c = 0; c < 2; c++) begin
			next_s.code_prev[c] = CHAN_IN[c].gain_code;
			if (CHAN_IN[c].gain_code != s.code_prev[c]) begin
				next_s.strobe[c] = ~s.strobe[c];
			end
			next_s.hist[c] = {s.hist[c][DELAY_DEPTH-2:0], CHAN_IN[c].gain_code};
			next_s.lut_out[c] = s.lut[CHAN_IN[c].lut_addr];
			// Bank select bit c belongs to channel c
			next_s.f1c[c] = s.ctrl2[C2_F1][c] ? f1_coef(s.f1b, CHAN_IN[c].f1_tap)
				: f1_coef(s.f1a, CHAN_IN[c].f1_tap);
			next_s.f2c[c] = s.ctrl2[C2_F2][c] ? f2_coef(s.f2b, CHAN_IN[c].f2_tap)
				: f2_coef(s.f2a, CHAN_IN[c].f2_tap);
		end
	end

	// Only SRST and bus writes alter stored register contents; there is no sync-in path
	always_ff @(posedge CLK) begin
		if (SRST) begin
			s <= '0;
			s.ctrl[IDX_DEBUG] <= RESET_DEBUG;
		end else begin
			s <= next_s;
		end
	end

	// Handshakes are combinational; address and data each stall on their own full slot and while a response is pending
	assign AWREADY = !s.aw_full && !s.bvalid;
	assign WREADY = !s.w_full && !s.bvalid;
	assign BVALID = s.bvalid;
	assign BRESP = s.bresp;
	assign ARREADY = !s.rvalid;
	assign RVALID = s.rvalid;
	assign RDATA = {24'h000000, s.rdata};
	assign RRESP = s.rresp;

	always_comb begin
		logic [4:0] dly;
		dly = s.ctrl2[C2_DET][DELAY_LSB +: 5];
		for (int c = 0; c < 2; c++) begin
			CHAN_OUT[c].f1_coef = s.f1c[c];
			CHAN_OUT[c].f2_coef = s.f2c[c];
			CHAN_OUT[c].lut_entry = s.lut_out[c];
			CHAN_OUT[c].amp_gain_code = s.code_prev[c];
			CHAN_OUT[c].amp_latch_strobe = s.strobe[c];
			// Zero delay passes the present code straight through
			if (dly == 5'h00) begin
				CHAN_OUT[c].comp_gain_code = CHAN_IN[c].gain_code;
			end else begin
				CHAN_OUT[c].comp_gain_code = s.hist[c][5'(dly - 5'h01)];
			end
		end
	end

	assign CFG.dec_ratio = {s.ctrl[IDX_DEC_HI][2:0], s.ctrl[IDX_DEC]};
	assign CFG.decimation_high_and_second_ratio = s.ctrl[IDX_DEC_HI][DECIMATION_HIGH_AND_SECOND_RATIO_BIT];
	assign CFG.scale_shift = s.ctrl[IDX_SCALE][5:0];
	assign CFG.gain_a = s.ctrl[IDX_GAIN_A][2:0];
	assign CFG.gain_b = s.ctrl[IDX_GAIN_B][2:0];
	assign CFG.out_rate = s.ctrl[IDX_RATE];
	assign CFG.serial_ctrl = s.ctrl[IDX_SERIAL];
	assign CFG.channel_a_tuning_frequency = {s.ctrl[IDX_CHANNEL_A_TUNING_FREQUENCY + 8'h03], s.ctrl[IDX_CHANNEL_A_TUNING_FREQUENCY + 8'h02],
		s.ctrl[IDX_CHANNEL_A_TUNING_FREQUENCY + 8'h01], s.ctrl[IDX_CHANNEL_A_TUNING_FREQUENCY]};
	assign CFG.phase_a = {s.ctrl[IDX_PHASE_A + 8'h01], s.ctrl[IDX_PHASE_A]};
	assign CFG.channel_b_tuning_frequency = {s.ctrl[IDX_CHANNEL_B_TUNING_FREQUENCY + 8'h03], s.ctrl[IDX_CHANNEL_B_TUNING_FREQUENCY + 8'h02],
		s.ctrl[IDX_CHANNEL_B_TUNING_FREQUENCY + 8'h01], s.ctrl[IDX_CHANNEL_B_TUNING_FREQUENCY]};
	assign CFG.phase_b = {s.ctrl[IDX_PHASE_B + 8'h01], s.ctrl[IDX_PHASE_B]};
	assign CFG.input_sel = s.ctrl[IDX_SOURCE][3:0];
	assign CFG.loop_ctrl = s.ctrl[IDX_LOOP_CTRL];
	assign CFG.loop_init_a = s.ctrl[IDX_INIT_A];
	assign CFG.loop_init_b = s.ctrl[IDX_INIT_B];
	assign CFG.test_ctrl = {s.ctrl[IDX_TEST + 8'h01][5:0], s.ctrl[IDX_TEST]};
	assign CFG.probe_ctrl = s.ctrl[IDX_DEBUG];
	assign CFG.first_filter_bank = s.ctrl2[C2_F1][1:0];
	assign CFG.second_filter_bank = s.ctrl2[C2_F2][1:0];
	assign CFG.frame_sync_mode = s.ctrl2[C2_SER][FRAME_MODE_BIT];
	assign CFG.daisy_chain_master_enable = s.ctrl2[C2_SER][DAISY_BIT];
	assign CFG.detector_comb_order = s.ctrl2[C2_DET][COMB_LSB +: 2];
	assign CFG.gain_step_align_delay = s.ctrl2[C2_DET][DELAY_LSB +: 5];

endmodule : ddcrm_top

// >>> ddcrm_top_assertions.sv
// Port checker for the downconverter register map.
// Assumes one clock domain; bound onto every ddcrm_top instance.
`timescale 1ns/1ps
module ddcrm_top_chk
	import ddcrm_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// Register bus
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic [1:0] BRESP,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic RVALID,
	input wire logic RREADY,
	input wire logic [31:0] RDATA,
	// Datapath side
	input ddcrm_chan_in_t [1:0] CHAN_IN,
	input ddcrm_chan_out_t [1:0] CHAN_OUT,
	input ddcrm_cfg_t CFG
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);

	property p_b_hold;
		BVALID && !BREADY |=> BVALID && $stable(BRESP);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold;
		RVALID && !RREADY |=> RVALID && $stable(RDATA);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	property p_r_lat;
		ARVALID && ARREADY |=> RVALID;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_b_lat;
		AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write answer late");
	property p_r_upper;
		RVALID |-> RDATA[31:8] == 24'h000000;
	endproperty
	a_r_upper: assert property (p_r_upper) else $error("upper read bits not zero");
	property p_strobe_cause;
		$changed(CHAN_OUT[0].amp_latch_strobe) |-> $changed(CHAN_OUT[0].amp_gain_code);
	endproperty
	a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without code change");
	property p_strobe_follow;
		$changed(CHAN_OUT[1].amp_gain_code) |-> $changed(CHAN_OUT[1].amp_latch_strobe);
	endproperty
	a_strobe_follow: assert property (p_strobe_follow) else $error("code change without strobe");
	property p_amp_code;
		!$past(SRST) |-> CHAN_OUT[0].amp_gain_code == $past(CHAN_IN[0].gain_code);
	endproperty
	a_amp_code: assert property (p_amp_code) else $error("amplifier code not one cycle late");
	property p_comp_delay;
		CFG.gain_step_align_delay == 5'h08 && $past(CFG.gain_step_align_delay, 9) == 5'h08
			|-> CHAN_OUT[0].comp_gain_code == $past(CHAN_IN[0].gain_code, 8);
	endproperty
	a_comp_delay: assert property (p_comp_delay) else $error("compensation delay wrong");
	property p_cfg_reset;
		$past(SRST) |-> CFG.first_filter_bank == 2'h0 && CFG.second_filter_bank == 2'h0
			&& {CFG.frame_sync_mode, CFG.daisy_chain_master_enable} == 2'h0
			&& CFG.detector_comb_order == 2'h0 && CFG.gain_step_align_delay == 5'h00;
	endproperty
	a_cfg_reset: assert property (p_cfg_reset) else $error("control fields not cleared");
endmodule : ddcrm_top_chk

bind ddcrm_top ddcrm_top_chk u_ddcrm_top_chk (.CLK(CLK), .SRST(SRST), .AWVALID(AWVALID),
	.AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
	.BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY),
	.RDATA(RDATA), .CHAN_IN(CHAN_IN), .CHAN_OUT(CHAN_OUT), .CFG(CFG));

// >>> tb_ddcrm_top.sv
// Self-checking bench for the downconverter register map.
// Assumes ddcrm_pkg, ddcrm_top and the checker are compiled before it.
`timescale 1ns/1ps
module tb_ddcrm_top;
	import ddcrm_pkg::*;
	typedef struct {
		logic [7:0] idx;
		logic [7:0] wd;
		logic [7:0] rd;
		logic [1:0] resp;
	} ddcrm_row_t;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, sa, sb;
	logic slow = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [1:0] bresp, rresp;
	ddcrm_chan_in_t [1:0] chan_in;
	ddcrm_chan_out_t [1:0] chan_out;
	ddcrm_cfg_t cfg;
	int mismatches = 0, checked = 0, cycles = 0;
	logic [7:0] lo [2] = '{8'hB4, 8'hF4};
	ddcrm_row_t rows [12] = '{'{8'hF6, 8'hFF, 8'h07, RESP_OKAY}, '{8'hF7, 8'hFF, 8'h07, RESP_OKAY},
		'{8'hF8, 8'hFF, 8'h03, RESP_OKAY}, '{8'hF9, 8'hFF, 8'h7F, RESP_OKAY},
		'{8'h01, 8'hFF, 8'h17, RESP_OKAY}, '{8'h02, 8'hFF, 8'h3F, RESP_OKAY},
		'{8'h03, 8'hFF, 8'h07, RESP_OKAY}, '{8'h13, 8'hFF, 8'h0F, RESP_OKAY},
		'{8'h14, 8'hFF, 8'h39, RESP_OKAY}, '{8'h1C, 8'hFF, 8'h3F, RESP_OKAY},
		'{8'hFA, 8'hFF, 8'h00, RESP_SLVERR}, '{8'h40, 8'hFF, 8'h00, RESP_SLVERR}};

	always #12.5 clk = ~clk;

	ddcrm_top u_ddcrm_top (.CLK(clk), .SRST(srst), .AWVALID(awvalid), .AWREADY(awready),
		.AWADDR(awaddr), .AWPROT(3'h0), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
		.WSTRB(4'hF), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
		.ARREADY(arready), .ARADDR(araddr), .ARPROT(3'h0), .RVALID(rvalid), .RREADY(rready),
		.RDATA(rdata), .RRESP(rresp), .CHAN_IN(chan_in), .CHAN_OUT(chan_out), .CFG(cfg));

	task automatic stop_test;
		if (mismatches == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Leading edge keeps ready/valid from being assigned twice in one step
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= !slow;
		do begin
			@(posedge clk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		// Slow mode raises ready only once the response is seen
		do begin
			@(posedge clk);
			if (bvalid === 1'b1 && bready !== 1'b1)
				bready <= 1'b1;
		end while (bvalid !== 1'b1 || bready !== 1'b1);
		chk({30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
		@(posedge clk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= !slow;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do begin
			@(posedge clk);
			if (rvalid === 1'b1 && rready !== 1'b1)
				rready <= 1'b1;
		end while (rvalid !== 1'b1 || rready !== 1'b1);
		chk(rdata, {24'h000000, e});
		chk({30'h0, rresp}, {30'h0, er});
		rready <= 1'b0;
	endtask : rd

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			stop_test();
		end
	end

	initial begin
		chan_in[0] = '{gain_code:3'h2, loop_readback:8'h3C, f1_tap:4'hA, f2_tap:5'h1F, lut_addr:5'h00};
		chan_in[1] = '{gain_code:3'h1, loop_readback:8'hC3, f1_tap:4'hA, f2_tap:5'h1F, lut_addr:5'h1F};
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		foreach (rows[i]) begin
			wr(rows[i].idx, rows[i].wd, rows[i].resp);
			rd(rows[i].idx, rows[i].rd, rows[i].resp);
		end
		rd(IDX_RB_A, 8'h3C, RESP_OKAY);
		rd(IDX_RB_B, 8'hC3, RESP_OKAY);
		// Second reset in mid-run after every upper control bit was set
		@(posedge clk);
		srst <= 1'b1;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		// Late ready until the table writes exercises the response hold checks
		slow = 1'b1;
		for (int i = 0; i < 4; i++)
			rd(IDX_FIRST_FILTER_BANK_CONTROL + 8'(i), 8'h00, RESP_OKAY);
		rd(IDX_DEBUG, RESET_DEBUG, RESP_OKAY);
		// Last tap of each filter, both pages, channels on opposite banks
		for (int f = 0; f < 2; f++) begin
			wr(lo[f], 8'h34, RESP_OKAY);
			wr(lo[f] + 8'h01, 8'h12, RESP_OKAY);
			wr(IDX_FIRST_FILTER_BANK_CONTROL + 8'(f), 8'h04, RESP_OKAY);
			wr(lo[f], 8'h78, RESP_OKAY);
			wr(lo[f] + 8'h01, 8'h56, RESP_OKAY);
			wr(IDX_FIRST_FILTER_BANK_CONTROL + 8'(f), 8'h06, RESP_OKAY);
			rd(lo[f] + 8'h01, 8'h56, RESP_OKAY);
			wr(IDX_FIRST_FILTER_BANK_CONTROL + 8'(f), 8'h02, RESP_OKAY);
			rd(lo[f], 8'h34, RESP_OKAY);
		end
		wr(IDX_LUT, 8'hA5, RESP_OKAY);
		wr(IDX_LUT_LAST, 8'h5A, RESP_OKAY);
		slow = 1'b0;
		wr(8'hF8, 8'h02, RESP_OKAY);
		wr(IDX_DET_CTRL, 8'h22, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk({16'h0, chan_out[0].f1_coef}, 32'h00001234);
		chk({16'h0, chan_out[1].f1_coef}, 32'h00005678);
		chk({16'h0, chan_out[0].f2_coef}, 32'h00001234);
		chk({16'h0, chan_out[1].f2_coef}, 32'h00005678);
		chk({24'h0, chan_out[0].lut_entry}, 32'h000000A5);
		chk({24'h0, chan_out[1].lut_entry}, 32'h0000005A);
		chk({23'h0, cfg.frame_sync_mode, cfg.daisy_chain_master_enable,
			cfg.detector_comb_order, cfg.gain_step_align_delay}, {23'h0, 9'h0C8});
		chk({28'h0, cfg.first_filter_bank, cfg.second_filter_bank}, 32'h0000000A);
		sa = chan_out[0].amp_latch_strobe;
		sb = chan_out[1].amp_latch_strobe;
		chan_in[0].gain_code <= 3'h5;
		repeat (3) @(posedge clk);
		chk({31'h0, chan_out[0].amp_latch_strobe}, {31'h0, ~sa});
		chk({31'h0, chan_out[1].amp_latch_strobe}, {31'h0, sb});
		chk({29'h0, chan_out[0].amp_gain_code}, 32'h00000005);
		// Eight periods after the change the old code is still showing, then the new one
		repeat (5) @(posedge clk);
		chk({29'h0, chan_out[0].comp_gain_code}, 32'h00000002);
		@(posedge clk);
		chk({29'h0, chan_out[0].comp_gain_code}, 32'h00000005);
		stop_test();
	end
endmodule : tb_ddcrm_top
